// ==== rtc_irq_ctrl.sv ====
// rtc interrupt steering, alarm compare and host register access
// assumes host pins are asynchronous; time and power-fail come from same-clock logic
// What this block does
// - watchdog enable set: time-out asserts the interrupt pin and sets its flag.
// - watchdog enable clear: time-out only sets the watchdog flag.
// - alarm enable set: alarm match asserts the interrupt pin and sets its flag.
// - alarm enable clear: alarm match only sets the alarm flag.
// - polarity bit one: interrupt pin driven actively high.
// - polarity bit zero: pin is open drain, pulled low when active.
// - pulse bit one: each enabled event holds the pin active about 200 ms.
// - pulse bit zero: pin stays active until the host reads the flags.
// - watchdog time-out is value times 31.25 ms; zero disables it.
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_ctrl
   import rtc_irq_pkg::*;
#(
   parameter int UNIT_CYC  = WDOG_UNIT_CYC,
   parameter int PULSE_CYC = IRQ_PULSE_CYC
) (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [16:0] addr_in,
   input  wire logic        chip_en_n_in,
   input  wire logic        write_en_n_in,
   input  wire logic        out_en_n_in,
   input  wire logic [7:0]  dq_in,
   output logic      [7:0]  dq_out,
   output logic             dq_oe_out,
   input  wire logic        time_update_in,
   input  wire logic [7:0]  minutes_in,
   input  wire logic [7:0]  hours_in,
   input  wire logic [7:0]  date_in,
   input  wire logic        powerfail_detect_in,
   output logic             int_out,
   output logic             int_oe_out
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [27:0] s1_r, s2_r, s3_r;
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         s1_r <= 28'h700_0000;
         s2_r <= 28'h700_0000;
         s3_r <= 28'h700_0000;
      end else begin
         s1_r <= {chip_en_n_in, write_en_n_in, out_en_n_in, addr_in, dq_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   logic        ce_n, we_n, oe_n, we_n_prev, ce_n_prev;
   logic [16:0] addr;
   logic [7:0]  wdata;
   assign {ce_n, we_n, oe_n, addr, wdata} = s2_r;
   assign ce_n_prev = s3_r[27];
   assign we_n_prev = s3_r[26];

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic        wr_stb, rd_act, rd_act_r, flags_read_end;
   logic [16:0] rd_addr_r;
   assign wr_stb = !we_n_prev && we_n && !ce_n_prev; // end of write cycle
   assign rd_act = !ce_n && !oe_n && we_n;
   assign flags_read_end = rd_act_r && !rd_act && rd_addr_r == OFS_FLAGS;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] alm_min_r, alm_min_nxt, alm_hour_r, alm_hour_nxt, alm_date_r, alm_date_nxt;
   logic [7:0] ctrl_r, ctrl_nxt, flags_r, flags_nxt;
   logic [5:0] wd_val_r, wd_val_nxt;
   logic       wd_lock_r, wd_lock_nxt, wd_restart;
   logic       wd_timeout, alarm_hit, alarm_evt, pf_evt, ev_en;

   // field compare with mask bit
   function automatic logic field_match(input logic [7:0] alarm_val, input logic [7:0] now);
      field_match = alarm_val[ALM_MASK_BIT] || (alarm_val[6:0] == now[6:0]);
   endfunction

   assign alarm_hit = field_match(alm_min_r, minutes_in) && field_match(alm_hour_r, hours_in)
                      && field_match(alm_date_r, date_in);
   assign alarm_evt = time_update_in && alarm_hit;
   assign pf_evt    = powerfail_detect_in;
   assign ev_en = (wd_timeout && ctrl_r[IC_WDOG_EN_BIT])
                || (alarm_evt && ctrl_r[IC_ALARM_EN_BIT])
                || (pf_evt && ctrl_r[IC_PFAIL_EN_BIT]);

   // register writes; hardware flag set wins over read clear
   always_comb begin
      alm_min_nxt  = alm_min_r;
      alm_hour_nxt = alm_hour_r;
      alm_date_nxt = alm_date_r;
      ctrl_nxt     = ctrl_r;
      wd_val_nxt   = wd_val_r;
      wd_lock_nxt  = wd_lock_r;
      wd_restart   = 1'b0;
      flags_nxt    = flags_r;
      if (wr_stb) begin
         case (addr)
            OFS_ALM_MIN:  alm_min_nxt  = wdata & MIN_WR_MASK;
            OFS_ALM_HOUR: alm_hour_nxt = wdata & HD_WR_MASK;
            OFS_ALM_DATE: alm_date_nxt = wdata & HD_WR_MASK;
            OFS_IRQ_CTRL: ctrl_nxt     = wdata & IC_WR_MASK;
            OFS_WDOG: begin
               wd_lock_nxt = wdata[WD_WRLOCK_BIT];
               wd_restart  = wdata[WD_STROBE_BIT];
               if (!wd_lock_r) begin
                  wd_val_nxt = wdata[5:0];
                  wd_restart = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (flags_read_end) begin
         flags_nxt = FLAGS_RST;
      end
      if (wd_timeout) begin
         flags_nxt[FL_WDOG_BIT] = 1'b1;
      end
      if (alarm_evt) begin
         flags_nxt[FL_ALARM_BIT] = 1'b1;
      end
      if (pf_evt) begin
         flags_nxt[FL_PFAIL_BIT] = 1'b1;
      end
   end

   // register state
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         alm_min_r  <= ALM_RST;
         alm_hour_r <= ALM_RST;
         alm_date_r <= ALM_RST;
         ctrl_r     <= IC_RST;
         wd_val_r   <= WD_VAL_RST;
         wd_lock_r  <= 1'b0;
         flags_r    <= FLAGS_RST;
      end else begin
         alm_min_r  <= alm_min_nxt;
         alm_hour_r <= alm_hour_nxt;
         alm_date_r <= alm_date_nxt;
         ctrl_r     <= ctrl_nxt;
         wd_val_r   <= wd_val_nxt;
         wd_lock_r  <= wd_lock_nxt;
         flags_r    <= flags_nxt;
      end
   end

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   rtc_watchdog #(
      .UNIT_CYC (UNIT_CYC)
   ) u_wdog (
      .sys_clk_in       (sys_clk_in),
      .rst_n_in         (rst_n_in),
      .timeout_value_in (wd_val_r),
      .restart_in       (wd_restart),
      .timeout_out      (wd_timeout)
   );

   // ----------------------------------------------------------------
   // interrupt hold: pulse timer or level latch
   // ----------------------------------------------------------------
   logic [31:0] pulse_cnt_r, pulse_cnt_nxt;
   logic        pend_r, pend_nxt, irq_active;
   assign irq_active = pend_r || (pulse_cnt_r != 32'h0000_0000);

   always_comb begin
      pulse_cnt_nxt = pulse_cnt_r;
      pend_nxt      = pend_r;
      if (pulse_cnt_r != 32'h0000_0000) begin
         pulse_cnt_nxt = pulse_cnt_r - 32'h0000_0001;
      end
      if (flags_read_end) begin
         pend_nxt = 1'b0;
      end
      if (ev_en && ctrl_r[IC_PULSE_BIT]) begin
         pulse_cnt_nxt = 32'(PULSE_CYC);
      end
      if (ev_en && !ctrl_r[IC_PULSE_BIT]) begin
         pend_nxt = 1'b1;
      end
   end

   // pin drive and read data
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pulse_cnt_r <= 32'h0000_0000;
         pend_r      <= 1'b0;
         int_out     <= 1'b0;
         int_oe_out  <= 1'b0;
         rd_act_r    <= 1'b0;
         rd_addr_r   <= 17'h0_0000;
         dq_out      <= 8'h00;
         dq_oe_out   <= 1'b0;
      end else begin
         pulse_cnt_r <= pulse_cnt_nxt;
         pend_r      <= pend_nxt;
         int_out     <= ctrl_r[IC_HIGH_BIT] && irq_active;
         int_oe_out  <= ctrl_r[IC_HIGH_BIT] || irq_active;
         rd_act_r    <= rd_act;
         rd_addr_r   <= addr;
         dq_oe_out   <= rd_act;
         case (addr)
            OFS_FLAGS:    dq_out <= flags_r;
            OFS_ALM_MIN:  dq_out <= alm_min_r;
            OFS_ALM_HOUR: dq_out <= alm_hour_r;
            OFS_ALM_DATE: dq_out <= alm_date_r;
            OFS_IRQ_CTRL: dq_out <= ctrl_r;
            OFS_WDOG:     dq_out <= {1'b0, wd_lock_r, wd_val_r};
            default:      dq_out <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence enabled_event_seq;
      ev_en && ctrl_r[IC_PULSE_BIT];
   endsequence

   chk_wdog_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      wd_timeout |=> flags_r[FL_WDOG_BIT])
      else $error("watchdog flag not set");
   chk_wdog_irq_on: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (wd_timeout && ctrl_r[IC_WDOG_EN_BIT]) |=> irq_active)
      else $error("enabled watchdog did not assert interrupt");
   chk_wdog_irq_off: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (wd_timeout && !ctrl_r[IC_WDOG_EN_BIT] && !(alarm_evt && ctrl_r[IC_ALARM_EN_BIT])
       && !(pf_evt && ctrl_r[IC_PFAIL_EN_BIT]) && !irq_active) |=> !irq_active)
      else $error("masked watchdog asserted interrupt");
   chk_alarm_irq_on: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (alarm_evt && ctrl_r[IC_ALARM_EN_BIT]) |=> (irq_active && flags_r[FL_ALARM_BIT]))
      else $error("enabled alarm did not assert interrupt");
   chk_alarm_flag_only: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (alarm_evt && !ctrl_r[IC_ALARM_EN_BIT] && !(wd_timeout && ctrl_r[IC_WDOG_EN_BIT])
       && !(pf_evt && ctrl_r[IC_PFAIL_EN_BIT]) && !irq_active)
      |=> (!irq_active && flags_r[FL_ALARM_BIT]))
      else $error("masked alarm misbehaved");
   chk_pin_high: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (ctrl_r[IC_HIGH_BIT] && irq_active) |=> (int_out && int_oe_out))
      else $error("active high pin not driven high");
   chk_pin_open_drain: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !ctrl_r[IC_HIGH_BIT] |=> (!int_out && int_oe_out == $past(irq_active)))
      else $error("open drain pin misdriven");
   chk_pulse_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      enabled_event_seq |=> irq_active [*2])
      else $error("pulse interrupt not held");
   chk_level_release: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (flags_read_end && !ev_en) |=> !pend_r)
      else $error("flags read did not release level interrupt");
   chk_alarm_all_masked: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (time_update_in && alm_min_r[ALM_MASK_BIT] && alm_hour_r[ALM_MASK_BIT]
       && alm_date_r[ALM_MASK_BIT]) |-> alarm_evt)
      else $error("fully masked alarm did not match");
   chk_pfail_irq: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (pf_evt && ctrl_r[IC_PFAIL_EN_BIT]) |=> (irq_active && flags_r[FL_PFAIL_BIT]))
      else $error("enabled power-fail did not assert interrupt");

endmodule
`default_nettype wire

// ==== rtc_irq_pkg.sv ====
// constants for the rtc interrupt steering and alarm compare block
// assumes a 250 mhz system clock and a byte-wide asynchronous host bus
package rtc_irq_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [16:0] OFS_FLAGS     = 17'h1_ffef;
   localparam logic [16:0] OFS_ALM_MIN   = 17'h1_fff3;
   localparam logic [16:0] OFS_ALM_HOUR  = 17'h1_fff4;
   localparam logic [16:0] OFS_ALM_DATE  = 17'h1_fff5;
   localparam logic [16:0] OFS_IRQ_CTRL  = 17'h1_fff6;
   localparam logic [16:0] OFS_WDOG      = 17'h1_fff7;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int IC_WDOG_EN_BIT  = 7;
   localparam int IC_ALARM_EN_BIT = 6;
   localparam int IC_PFAIL_EN_BIT = 5;
   localparam int IC_HIGH_BIT     = 3;
   localparam int IC_PULSE_BIT    = 2;
   localparam int WD_STROBE_BIT   = 7;
   localparam int WD_WRLOCK_BIT   = 6;
   localparam int ALM_MASK_BIT    = 7;
   localparam int FL_WDOG_BIT     = 7;
   localparam int FL_ALARM_BIT    = 6;
   localparam int FL_PFAIL_BIT    = 5;

   // ----------------------------------------------------------------
   // writable bits and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] MIN_WR_MASK   = 8'hff;
   localparam logic [7:0] HD_WR_MASK    = 8'hbf;
   localparam logic [7:0] IC_WR_MASK    = 8'hec;
   localparam logic [7:0] ALM_RST       = 8'h00;
   localparam logic [7:0] IC_RST        = 8'h00;
   localparam logic [5:0] WD_VAL_RST    = 6'h00;
   localparam logic [7:0] FLAGS_RST     = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int WDOG_UNIT_NS  = 31_250_000;
   localparam int IRQ_PULSE_NS  = 200_000_000;
   localparam int WDOG_UNIT_CYC = WDOG_UNIT_NS / CLK_PERIOD_NS;
   localparam int IRQ_PULSE_CYC = IRQ_PULSE_NS / CLK_PERIOD_NS;

endpackage

// ==== rtc_watchdog.sv ====
// watchdog timer: counts 31.25 ms units up to the programmed time-out
// assumes value and strobe come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module rtc_watchdog
   import rtc_irq_pkg::*;
#(
   parameter int UNIT_CYC = WDOG_UNIT_CYC
) (
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [5:0] timeout_value_in,
   input  wire logic       restart_in,
   output logic            timeout_out
);

   logic [31:0] pre_r,  pre_nxt;
   logic [5:0]  unit_r, unit_nxt;
   logic        to_r,   to_nxt;

   // ----------------------------------------------------------------
   // prescaler and unit counter
   // ----------------------------------------------------------------
   // zero value holds everything idle; timeout restarts the count
   always_comb begin
      pre_nxt  = pre_r;
      unit_nxt = unit_r;
      to_nxt   = 1'b0;
      if (restart_in || timeout_value_in == 6'h00) begin
         pre_nxt  = 32'h0000_0000;
         unit_nxt = 6'h00;
      end else if (pre_r == 32'(UNIT_CYC - 1)) begin
         pre_nxt = 32'h0000_0000;
         if (unit_r + 6'h01 >= timeout_value_in) begin
            unit_nxt = 6'h00;
            to_nxt   = 1'b1;
         end else begin
            unit_nxt = unit_r + 6'h01;
         end
      end else begin
         pre_nxt = pre_r + 32'h0000_0001;
      end
   end

   // registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pre_r  <= 32'h0000_0000;
         unit_r <= 6'h00;
         to_r   <= 1'b0;
      end else begin
         pre_r  <= pre_nxt;
         unit_r <= unit_nxt;
         to_r   <= to_nxt;
      end
   end

   assign timeout_out = to_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_wdog_disabled: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (timeout_value_in == 6'h00) |=> !to_r)
      else $error("watchdog fired while disabled");

   chk_wdog_period: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      to_r |-> ($past(pre_r) == 32'(UNIT_CYC - 1)))
      else $error("watchdog fired off a unit boundary");

endmodule
`default_nettype wire

// ==== host_model.sv ====
// host processor model driving the asynchronous byte-wide register bus
// assumes the bench clock; every strobe changes just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic        clk_in,
   input  wire logic [7:0]  rd_data_in,
   input  wire logic        rd_valid_in,
   output logic      [16:0] addr_out,
   output logic             ce_n_out,
   output logic             we_n_out,
   output logic             oe_n_out,
   output logic      [7:0]  wr_data_out
);
   // ----------------------------------------------------------------
   // idle bus and cycle helper
   // ----------------------------------------------------------------
   initial begin
      addr_out    = 17'h0_0000;
      ce_n_out    = 1'b1;
      we_n_out    = 1'b1;
      oe_n_out    = 1'b1;
      wr_data_out = 8'h00;
   end

   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // write: address and data settle before the strobe, stay after it
   task automatic wr(input logic [16:0] a, input logic [7:0] d);
      addr_out    <= a;
      wr_data_out <= d;
      idle(4);
      ce_n_out <= 1'b0;
      we_n_out <= 1'b0;
      idle(4);
      we_n_out <= 1'b1;
      idle(4);
      ce_n_out    <= 1'b1;
      addr_out    <= ~a;   // released lines do not keep the last value
      wr_data_out <= ~d;
      idle(4);
   endtask

   // read: data taken at the edge the device shows it driving
   task automatic rd(input logic [16:0] a, output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d  = 8'h00;
      addr_out <= a;
      idle(2);
      ce_n_out <= 1'b0;
      oe_n_out <= 1'b0;
      for (int i = 0; i < 12 && !ok; i++) begin
         @(posedge clk_in);
         if (rd_valid_in === 1'b1) begin
            ok = 1'b1;
            d  = rd_data_in;
         end
      end
      ce_n_out <= 1'b1;   // ending a read of the flags register releases a level interrupt
      oe_n_out <= 1'b1;
      addr_out <= ~a;
      idle(6);
   endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the rtc interrupt steering block
// assumes the host model file and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rtc_irq_pkg::*;
   localparam int UNIT  = 10;
   localparam int PULSE = 20;
   localparam logic [16:0] REG_OFS [4] = '{OFS_ALM_MIN, OFS_ALM_HOUR, OFS_ALM_DATE, OFS_IRQ_CTRL};
   localparam logic [7:0]  REG_MSK [4] = '{MIN_WR_MASK, HD_WR_MASK, HD_WR_MASK, IC_WR_MASK};

   logic        sys_clk_in, rst_n_in, ce_n, we_n, oe_n, dq_oe_out, time_update_in;
   logic        powerfail_detect_in, int_out, int_oe_out, int_pin;
   logic [16:0] addr;
   logic [7:0]  dq_wr, dq_out, minutes_in, hours_in, date_in;
   int          n_errors, n_checks;

   // ----------------------------------------------------------------
   // clock, host, device and pulled-up interrupt wire
   // ----------------------------------------------------------------
   initial begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end

   host_model host (.clk_in(sys_clk_in), .rd_data_in(dq_out), .rd_valid_in(dq_oe_out),
      .addr_out(addr), .ce_n_out(ce_n), .we_n_out(we_n), .oe_n_out(oe_n), .wr_data_out(dq_wr));

   rtc_irq_ctrl #(.UNIT_CYC(UNIT), .PULSE_CYC(PULSE)) dut (.sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in), .addr_in(addr), .chip_en_n_in(ce_n), .write_en_n_in(we_n),
      .out_en_n_in(oe_n), .dq_in(dq_wr), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
      .time_update_in(time_update_in), .minutes_in(minutes_in), .hours_in(hours_in),
      .date_in(date_in), .powerfail_detect_in(powerfail_detect_in), .int_out(int_out),
      .int_oe_out(int_oe_out));

   assign int_pin = int_oe_out ? int_out : 1'b1;   // external pull-up when released

   // ----------------------------------------------------------------
   // compare, access and event tasks
   // ----------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk1(input string name, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic rd_chk(input logic [16:0] a, input logic [7:0] exp, input string name);
      logic [7:0] d;
      bit         ok;
      host.rd(a, d, ok);
      if (!ok) begin
         n_errors++;
         $display("[FAIL] %s expected answer seen none", name);
         final_report();
      end
      chk8(name, exp, d);
   endtask

   // flags read whose value is not fixed; releases a level interrupt
   task automatic flush_flags;
      logic [7:0] d;
      bit         ok;
      host.rd(OFS_FLAGS, d, ok);
      if (!ok) begin
         n_errors++;
         $display("[FAIL] flags flush expected answer seen none");
         final_report();
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask

   // one-cycle time update with the given bcd fields
   task automatic tick(input logic [7:0] m, input logic [7:0] h, input logic [7:0] d);
      @(posedge sys_clk_in);
      minutes_in     <= m;
      hours_in       <= h;
      date_in        <= d;
      time_update_in <= 1'b1;
      @(posedge sys_clk_in);
      time_update_in <= 1'b0;
   endtask

   task automatic pfail;
      @(posedge sys_clk_in);
      powerfail_detect_in <= 1'b1;
      @(posedge sys_clk_in);
      powerfail_detect_in <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      n_errors = 0;
      n_checks = 0;
      rst_n_in = 1'b0;
      time_update_in = 1'b0;
      powerfail_detect_in = 1'b0;
      minutes_in = 8'h00;
      hours_in = 8'h00;
      date_in = 8'h00;
      cyc(6);
      rst_n_in <= 1'b1;
      cyc(2);
      chk1("pin after reset", 1'b1, int_pin);
      rd_chk(OFS_FLAGS, FLAGS_RST, "flags reset");
      // reset value, writable bits and clear of the three alarm registers and the control register
      for (int i = 0; i < 4; i++) begin
         rd_chk(REG_OFS[i], 8'h00, "reg reset");
         host.wr(REG_OFS[i], 8'hff);
         rd_chk(REG_OFS[i], REG_MSK[i], "reg ones");
         host.wr(REG_OFS[i], 8'h00);
         rd_chk(REG_OFS[i], 8'h00, "reg zeros");
      end
      host.wr(17'h1_fff0, 8'h5a);
      rd_chk(17'h1_fff0, 8'h00, "unmapped");
      // power failure, disabled then enabled in level open-drain mode
      pfail();
      cyc(4);
      chk1("pf off oe", 1'b0, int_oe_out);
      rd_chk(OFS_FLAGS, 8'h20, "pf flag");
      host.wr(OFS_IRQ_CTRL, 8'h20);
      pfail();
      cyc(3);
      chk1("pf pin low", 1'b0, int_pin);
      cyc(PULSE + 10);
      chk1("pf level held", 1'b0, int_pin);
      rd_chk(OFS_FLAGS, 8'h20, "pf flag on");
      cyc(3);
      chk1("pf released", 1'b1, int_pin);
      // alarm disabled, minutes masked, hours and date (zero) compared
      host.wr(OFS_IRQ_CTRL, 8'h08);
      host.wr(OFS_ALM_MIN, 8'h80);
      host.wr(OFS_ALM_HOUR, 8'h05);
      tick(8'h17, 8'h06, 8'h00);
      rd_chk(OFS_FLAGS, 8'h00, "hour miss");
      tick(8'h17, 8'h05, 8'h00);
      cyc(3);
      chk1("alarm off pin", 1'b0, int_pin);
      rd_chk(OFS_FLAGS, 8'h40, "alarm flag");
      // alarm enabled, active high pulse
      host.wr(OFS_ALM_MIN, 8'h30);
      host.wr(OFS_ALM_HOUR, 8'h80);
      host.wr(OFS_ALM_DATE, 8'h80);
      host.wr(OFS_IRQ_CTRL, 8'h4c);
      tick(8'h31, 8'h05, 8'h12);
      cyc(3);
      chk1("minute miss", 1'b0, int_pin);
      tick(8'h30, 8'h05, 8'h12);
      cyc(3);
      chk1("alarm pin high", 1'b1, int_pin);
      chk1("alarm driven", 1'b1, int_oe_out);
      cyc(PULSE - 6);
      chk1("pulse held", 1'b1, int_pin);
      cyc(8);
      chk1("pulse ends", 1'b0, int_pin);
      rd_chk(OFS_FLAGS, 8'h40, "alarm flag on");
      // watchdog, enable clear then set, then disabled by zero
      host.wr(OFS_IRQ_CTRL, 8'h08);
      host.wr(OFS_WDOG, 8'h03);
      cyc(40);
      chk1("wdog off pin", 1'b0, int_pin);
      rd_chk(OFS_FLAGS, 8'h80, "wdog flag");
      host.wr(OFS_WDOG, 8'h00);
      flush_flags();
      host.wr(OFS_IRQ_CTRL, 8'h88);
      host.wr(OFS_WDOG, 8'h03);
      cyc(20);
      chk1("wdog early", 1'b0, int_pin);
      cyc(12);
      chk1("wdog pin high", 1'b1, int_pin);
      host.wr(OFS_WDOG, 8'h00);
      rd_chk(OFS_FLAGS, 8'h80, "wdog flag on");
      cyc(6 * UNIT);
      chk1("wdog stopped", 1'b0, int_pin);
      rd_chk(OFS_FLAGS, 8'h00, "no wdog flag");
      final_report();
   end
endmodule
`default_nettype wire
